// ==== hdl/cbp_unit.sv ====
// Local design decisions: the register offsets and the APB interface to the registers.
`timescale 1ns/1ps
`default_nettype none

// Notes on behaviour
// - compare value checked against assigned timer
// - match drives, clears, toggles pin, sets flag
// - compare codes 0010, 1000, 1001, 1010, 1011
// - code 1010: flag only, pin untouched
// - code 1011: trigger resets assigned timer
// - trigger starts conversion only if enabled
// - zero control write forces compare pin low
// - assign 000 first timer, 001-011 second
// - pwm on four outputs, 10-bit duty
// - config 10 half, 01/11 full bridge
// - polarity per pair from low mode bits
// - codes 1100-1111 select pair polarities
// - pwm starts only at new period
// - 10-bit base: period timer plus 2 bits
// - period is 4*(limit+1)*prescale clocks
// - width is duty*prescale clocks
// - low duty bits from control register
// - half bridge: b is complement of a
// - dead band delays active edge, 4 clocks/unit
// - dead band beyond duty keeps output inactive
// - forward: a active, d modulated, b c off
// - reverse: c active, b modulated, a d off
module cbp_unit (
  // clock and reset
  input wire logic clock_i,
  input wire logic reset_i,
  // register bus
  input wire cbp_pkg::cbp_apb_req_t apb_i,
  output cbp_pkg::cbp_apb_rsp_t apb_o,
  // timer counts and converter state
  input wire logic [15:0] first_timer_i,
  input wire logic [15:0] second_timer_i,
  input wire logic adc_enabled_i,
  // triggers
  output logic [1:0] timer_reset_o,
  output logic adc_start_o,
  // pins
  output logic compare_pin_o,
  output logic compare_pin_oe_o,
  output logic [3:0] pwm_out_o,
  output logic [3:0] pwm_oe_o
);
  // registers
  logic [7:0] ctrl_r;
  logic [7:0] duty_high_r;
  logic [15:0] cmp_r;
  logic [6:0] dead_r;
  logic [2:0] tsel_r;
  logic [7:0] plim_r;
  logic [1:0] pre_r;
  logic flag_r;
  logic cmp_pin_r;
  logic eq_d_r;
  logic [1:0] trig_r;
  logic adc_r;
  logic pready_r;
  logic pslverr_r;
  logic [31:0] prdata_r;
  logic [4:0] pre_cnt_r;
  logic [1:0] q_r;
  logic [7:0] ptmr_r;
  logic run_r;
  logic [8:0] db_a_r;
  logic [8:0] db_b_r;
  logic [3:0] pwm_r;
  logic [3:0] oe_r;
  logic cmp_oe_r;

  function automatic logic [8:0] db_next(input logic want,
                                         input logic [8:0] cnt,
                                         input logic [8:0] load);
    logic [8:0] n;
    n = 9'h000;
    if (!want)
      n = load;
    else if (cnt != 9'h000)
      n = cnt - 9'h001;
    return n;
  endfunction

  // bus decode
  wire logic access = apb_i.psel && apb_i.penable;
  wire logic wr_en = access && pready_r && apb_i.pwrite;
  wire logic hit_ctrl = apb_i.paddr == cbp_pkg::OFS_CONTROL;
  wire logic hit_duty = apb_i.paddr == cbp_pkg::OFS_DUTY_HIGH;
  wire logic hit_cmp = apb_i.paddr == cbp_pkg::OFS_COMPARE;
  wire logic hit_dead = apb_i.paddr == cbp_pkg::OFS_DEADBAND;
  wire logic hit_tsel = apb_i.paddr == cbp_pkg::OFS_TIMER_ASSIGN;
  wire logic hit_plim = apb_i.paddr == cbp_pkg::OFS_PERIOD_LIMIT;
  wire logic hit_pre = apb_i.paddr == cbp_pkg::OFS_PRESCALE;
  wire logic hit_stat = apb_i.paddr == cbp_pkg::OFS_STATUS;
  wire logic mapped = hit_ctrl | hit_duty | hit_cmp | hit_dead | hit_tsel
                      | hit_plim | hit_pre | hit_stat;
  wire logic wr_ctrl = wr_en && hit_ctrl;
  wire logic flag_clr = wr_en && hit_stat && apb_i.pwdata[cbp_pkg::ST_FLAG];

  wire logic [3:0] mode = ctrl_r[3:0];
  wire logic [1:0] cfg = ctrl_r[cbp_pkg::CFG_LSB +: 2];
  wire logic pwm_on = mode[3:2] == cbp_pkg::MODE_PWM_TOP;

  // compare section
  wire logic is_cmp = (mode == cbp_pkg::MODE_TOGGLE)
                      || (mode[3:2] == 2'h2);
  wire logic sel_first = tsel_r == cbp_pkg::TSEL_FIRST;
  wire logic sel_second = (tsel_r != cbp_pkg::TSEL_FIRST)
                          && (tsel_r <= cbp_pkg::TSEL_SECOND_LAST);
  wire logic [15:0] base_cnt = sel_first ? first_timer_i : second_timer_i;
  // reserved assignment codes never match
  wire logic eq_now = is_cmp && (sel_first || sel_second)
                      && (base_cnt == cmp_r);
  // act once per match: the timer may sit on the value for many clocks
  wire logic match_ev = eq_now && !eq_d_r;
  wire logic fire_trig = match_ev && (mode == cbp_pkg::MODE_TRIGGER);
  wire logic [1:0] trig_nxt = fire_trig ? {sel_second, sel_first}
                                        : 2'h0;

  logic pin_nxt;
  always_comb begin
    pin_nxt = cmp_pin_r;
    if (wr_ctrl && apb_i.pwdata[7:0] == 8'h00)
      pin_nxt = 1'b0;
    else if (wr_ctrl && apb_i.pwdata[3:0] == cbp_pkg::MODE_SET)
      pin_nxt = 1'b0;
    else if (wr_ctrl && apb_i.pwdata[3:0] == cbp_pkg::MODE_CLEAR)
      pin_nxt = 1'b1;
    else if (match_ev) begin
      case (mode)
        cbp_pkg::MODE_TOGGLE: pin_nxt = !cmp_pin_r;
        cbp_pkg::MODE_SET: pin_nxt = 1'b1;
        cbp_pkg::MODE_CLEAR: pin_nxt = 1'b0;
        default: pin_nxt = cmp_pin_r;
      endcase
    end
  end

  // set wins over a clear in the same cycle
  wire logic flag_nxt = match_ev || (flag_r && !flag_clr);
  wire logic cmp_oe_nxt = (mode == cbp_pkg::MODE_TOGGLE)
                          || (mode == cbp_pkg::MODE_SET)
                          || (mode == cbp_pkg::MODE_CLEAR);

  // pwm time base
  wire logic [4:0] div = (pre_r == cbp_pkg::PRE_DIV1) ? cbp_pkg::DIV1 :
                         (pre_r == cbp_pkg::PRE_DIV4) ? cbp_pkg::DIV4 :
                         cbp_pkg::DIV16;
  wire logic tick = pre_cnt_r == (div - 5'h01);
  wire logic q_wrap = tick && (q_r == cbp_pkg::Q_LAST);
  wire logic period_start = q_wrap && (ptmr_r == plim_r);
  wire logic [4:0] pre_nxt = tick ? 5'h00 : pre_cnt_r + 5'h01;
  wire logic [1:0] q_nxt = tick ? q_r + 2'h1 : q_r;
  wire logic [7:0] ptmr_nxt = period_start ? 8'h00 :
                              q_wrap ? ptmr_r + 8'h01 : ptmr_r;
  wire logic [9:0] base10 = {ptmr_r, q_r};
  wire logic [9:0] duty10 = {duty_high_r,
                             ctrl_r[cbp_pkg::DLOW_LSB +: 2]};
  wire logic raw = base10 < duty10;
  // hold off until a period boundary so no partial pulse appears
  wire logic run_nxt = pwm_on && (run_r || period_start);

  // dead band only in half bridge, in instruction cycles
  wire logic half = cfg == cbp_pkg::CFG_HALF;
  wire logic [8:0] db_load = half ? 9'(dead_r) * 9'(cbp_pkg::CLKS_PER_ICYCLE)
                                  : 9'h000;
  wire logic [8:0] db_a_nxt = db_next(run_r && raw, db_a_r, db_load);
  wire logic [8:0] db_b_nxt = db_next(run_r && !raw, db_b_r, db_load);
  // an output whose delay outlasts its active time never turns on
  wire logic a_half = run_r && raw && db_a_r == 9'h000;
  wire logic b_half = run_r && !raw && db_b_r == 9'h000;

  logic [3:0] act_nxt;
  logic [3:0] oe_nxt;
  always_comb begin
    act_nxt = 4'h0;
    oe_nxt = 4'h0;
    if (pwm_on) begin
      case (cfg)
        cbp_pkg::CFG_SINGLE: begin
          act_nxt = {3'h0, run_r && raw};
          oe_nxt = 4'h1;
        end
        cbp_pkg::CFG_HALF: begin
          act_nxt = {2'h0, b_half, a_half};
          oe_nxt = 4'h3;
        end
        cbp_pkg::CFG_FWD: begin
          act_nxt = {run_r && raw, 2'h0, run_r};
          oe_nxt = 4'hF;
        end
        cbp_pkg::CFG_REV: begin
          act_nxt = {1'b0, run_r, run_r && raw, 1'b0};
          oe_nxt = 4'hF;
        end
        default: begin
          act_nxt = 4'h0;
          oe_nxt = 4'h0;
        end
      endcase
    end
  end
  // mode bit 1 inverts pair a/c, bit 0 inverts pair b/d
  wire logic [3:0] pol = {mode[0], mode[1], mode[0], mode[1]};
  wire logic [3:0] pwm_nxt = pwm_on ? act_nxt ^ pol : 4'h0;

  // read path
  wire logic [7:0] status = {pwm_r, 1'b0, run_r, cmp_pin_r, flag_r};
  wire logic [31:0] rd_mux =
    hit_ctrl ? {24'h0, ctrl_r} :
    hit_duty ? {24'h0, duty_high_r} :
    hit_cmp ? {16'h0, cmp_r} :
    hit_dead ? {25'h0, dead_r} :
    hit_tsel ? {29'h0, tsel_r} :
    hit_plim ? {24'h0, plim_r} :
    hit_pre ? {30'h0, pre_r} :
    hit_stat ? {24'h0, status} : 32'h0;
  wire logic rdy_nxt = access && !pready_r;

  always_ff @(posedge clock_i) begin
    if (reset_i) begin
      ctrl_r <= cbp_pkg::CONTROL_RESET;
      duty_high_r <= 8'h00;
      cmp_r <= 16'h0000;
      dead_r <= 7'h00;
      tsel_r <= 3'h0;
      plim_r <= 8'h00;
      pre_r <= 2'h0;
    end else if (wr_en) begin
      if (hit_ctrl) ctrl_r <= apb_i.pwdata[7:0];
      if (hit_duty) duty_high_r <= apb_i.pwdata[7:0];
      if (hit_cmp) cmp_r <= apb_i.pwdata[15:0];
      if (hit_dead) dead_r <= apb_i.pwdata[6:0];
      if (hit_tsel) tsel_r <= apb_i.pwdata[2:0];
      if (hit_plim) plim_r <= apb_i.pwdata[7:0];
      if (hit_pre) pre_r <= apb_i.pwdata[1:0];
    end
  end

  always_ff @(posedge clock_i) begin
    if (reset_i) begin
      pready_r <= 1'b0;
      pslverr_r <= 1'b0;
      prdata_r <= 32'h0;
    end else begin
      pready_r <= rdy_nxt;
      pslverr_r <= rdy_nxt && !mapped;
      prdata_r <= (rdy_nxt && !apb_i.pwrite) ? rd_mux : 32'h0;
    end
  end

  always_ff @(posedge clock_i) begin
    if (reset_i) begin
      flag_r <= 1'b0;
      cmp_pin_r <= 1'b0;
      cmp_oe_r <= 1'b0;
      eq_d_r <= 1'b0;
      trig_r <= 2'h0;
      adc_r <= 1'b0;
    end else begin
      flag_r <= flag_nxt;
      cmp_pin_r <= pin_nxt;
      cmp_oe_r <= cmp_oe_nxt;
      eq_d_r <= eq_now;
      trig_r <= trig_nxt;
      adc_r <= fire_trig && adc_enabled_i;
    end
  end

  always_ff @(posedge clock_i) begin
    if (reset_i) begin
      pre_cnt_r <= 5'h00;
      q_r <= 2'h0;
      ptmr_r <= 8'h00;
      run_r <= 1'b0;
      db_a_r <= 9'h000;
      db_b_r <= 9'h000;
      pwm_r <= 4'h0;
      oe_r <= 4'h0;
    end else begin
      pre_cnt_r <= pre_nxt;
      q_r <= q_nxt;
      ptmr_r <= ptmr_nxt;
      run_r <= run_nxt;
      db_a_r <= db_a_nxt;
      db_b_r <= db_b_nxt;
      pwm_r <= pwm_nxt;
      oe_r <= oe_nxt;
    end
  end

  assign apb_o = '{pready: pready_r, pslverr: pslverr_r, prdata: prdata_r};
  assign timer_reset_o = trig_r;
  assign adc_start_o = adc_r;
  assign compare_pin_o = cmp_pin_r;
  assign compare_pin_oe_o = cmp_oe_r;
  assign pwm_out_o = pwm_r;
  assign pwm_oe_o = oe_r;

  default clocking cb @(posedge clock_i); endclocking
  default disable iff (reset_i);

  a_match_sets_flag: assert property (match_ev |=> flag_r)
    else $error("match did not set flag");
  a_toggle_pin_flips: assert property (
    match_ev && mode == cbp_pkg::MODE_TOGGLE && !wr_ctrl
    |=> cmp_pin_r != $past(cmp_pin_r))
    else $error("toggle mode did not flip pin");
  a_flag_only_pin: assert property (
    match_ev && mode == cbp_pkg::MODE_FLAG && !wr_ctrl
    |=> $stable(cmp_pin_r))
    else $error("flag-only mode changed pin");
  a_trigger_resets_timer: assert property (
    match_ev && mode == cbp_pkg::MODE_TRIGGER
    |=> timer_reset_o == ($past(sel_first) ? 2'h1 : 2'h2)
    ##1 timer_reset_o == 2'h0)
    else $error("trigger did not pulse assigned timer reset");
  a_adc_needs_enable: assert property (
    adc_start_o |-> $past(adc_enabled_i) && timer_reset_o != 2'h0)
    else $error("conversion started without enable");
  a_zero_ctrl_low: assert property (
    wr_ctrl && apb_i.pwdata[7:0] == 8'h00 |=> !cmp_pin_r)
    else $error("zero control write left pin high");
  a_flag_stays_set: assert property (
    flag_r && !flag_clr |=> flag_r)
    else $error("flag dropped without clear");
  a_start_at_period: assert property (
    $rose(run_r) |-> $past(period_start) && $past(pwm_on))
    else $error("pwm started mid period");
  a_forward_levels: assert property (
    pwm_on && run_r && cfg == cbp_pkg::CFG_FWD
    |-> act_nxt[0] && !act_nxt[1] && !act_nxt[2])
    else $error("forward mode levels wrong");
  a_reverse_levels: assert property (
    pwm_on && run_r && cfg == cbp_pkg::CFG_REV
    |-> act_nxt[2] && !act_nxt[0] && !act_nxt[3])
    else $error("reverse mode levels wrong");
  a_half_no_overlap: assert property (
    pwm_on && half |-> !(act_nxt[0] && act_nxt[1]))
    else $error("half bridge outputs overlap");

  c_toggle_match: cover property (match_ev && mode == cbp_pkg::MODE_TOGGLE);
  c_trigger_adc: cover property (adc_start_o);
  c_half_run: cover property (run_r && half ##1 pwm_oe_o == 4'h3);
  c_period_wrap: cover property (run_r && period_start);
endmodule

`default_nettype wire

// ==== shared/cbp_pkg.sv ====
package cbp_pkg;
  // register byte offsets
  localparam logic [7:0] OFS_CONTROL = 8'h00;
  localparam logic [7:0] OFS_DUTY_HIGH = 8'h04;
  localparam logic [7:0] OFS_COMPARE = 8'h08;
  localparam logic [7:0] OFS_DEADBAND = 8'h0C;
  localparam logic [7:0] OFS_TIMER_ASSIGN = 8'h10;
  localparam logic [7:0] OFS_PERIOD_LIMIT = 8'h14;
  localparam logic [7:0] OFS_PRESCALE = 8'h18;
  localparam logic [7:0] OFS_STATUS = 8'h1C;
  // control register fields
  localparam int CFG_LSB = 6;
  localparam int DLOW_LSB = 4;
  localparam logic [7:0] CONTROL_RESET = 8'h00;
  // mode_select_field codes
  localparam logic [3:0] MODE_TOGGLE = 4'h2;
  localparam logic [3:0] MODE_SET = 4'h8;
  localparam logic [3:0] MODE_CLEAR = 4'h9;
  localparam logic [3:0] MODE_FLAG = 4'hA;
  localparam logic [3:0] MODE_TRIGGER = 4'hB;
  localparam logic [1:0] MODE_PWM_TOP = 2'h3;
  // output_config_field codes
  localparam logic [1:0] CFG_SINGLE = 2'h0;
  localparam logic [1:0] CFG_FWD = 2'h1;
  localparam logic [1:0] CFG_HALF = 2'h2;
  localparam logic [1:0] CFG_REV = 2'h3;
  // timer assignment codes
  localparam logic [2:0] TSEL_FIRST = 3'h0;
  localparam logic [2:0] TSEL_SECOND_LAST = 3'h3;
  // prescale codes and divide-by values
  localparam logic [1:0] PRE_DIV1 = 2'h0;
  localparam logic [1:0] PRE_DIV4 = 2'h1;
  localparam logic [4:0] DIV1 = 5'h01;
  localparam logic [4:0] DIV4 = 5'h04;
  localparam logic [4:0] DIV16 = 5'h10;
  // one instruction cycle is four clocks
  localparam int CLKS_PER_ICYCLE = 4;
  localparam logic [1:0] Q_LAST = 2'h3;
  // status register fields
  localparam int ST_FLAG = 0;
  localparam int ST_PIN = 1;
  localparam int ST_RUN = 2;
  localparam int ST_OUT_LSB = 4;

  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [7:0] paddr;
    logic [31:0] pwdata;
  } cbp_apb_req_t;

  typedef struct packed {
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
  } cbp_apb_rsp_t;
endpackage

// ==== verif/cbp_timer_model.sv ====
`timescale 1ns/1ps
`default_nettype none

// two base timers counting on the system clock, wrapping at WRAP
// a short wrap keeps every compare match within a few dozen cycles
module cbp_timer_model #(
  parameter int WRAP = 64
) (
  // clock and reset
  input wire logic clock_i,
  input wire logic reset_i,
  // trigger from the unit
  input wire logic [1:0] timer_reset_i,
  // live counts
  output logic [15:0] first_timer_o,
  output logic [15:0] second_timer_o
);
  // synchronous counting only, no asynchronous counter mode
  always_ff @(posedge clock_i) begin
    if (reset_i || timer_reset_i[0] || first_timer_o == 16'(WRAP - 1))
      first_timer_o <= 16'h0000;
    else
      first_timer_o <= first_timer_o + 16'h0001;
    if (reset_i || timer_reset_i[1] || second_timer_o == 16'(WRAP - 1))
      second_timer_o <= 16'h0000;
    else
      second_timer_o <= second_timer_o + 16'h0001;
  end
endmodule

`default_nettype wire

// ==== verif/cbp_unit_tb.sv ====
`timescale 1ns/1ps
`default_nettype none

module cbp_unit_tb;
  localparam int WRAP = 64;
  logic clock_i = 1'b0;
  logic reset_i = 1'b1;
  logic adc_en = 1'b0;
  cbp_pkg::cbp_apb_req_t req = '0;
  cbp_pkg::cbp_apb_rsp_t rsp;
  logic [15:0] t1, t2;
  logic [1:0] trst;
  logic adc_go, cpin, cpin_oe;
  logic [3:0] pwm, pwm_en;
  logic [32:0] expq[$];
  logic [15:0] v;
  logic [3:0] modes[4] = '{4'hA, 4'h8, 4'h9, 4'h2};
  logic pins[4] = '{1'b0, 1'b1, 1'b0, 1'b1};
  int errors = 0;
  int checks_done = 0;
  int cycles = 0;
  int d;

  always #2.5 clock_i = ~clock_i;

  cbp_unit dut (.clock_i(clock_i), .reset_i(reset_i), .apb_i(req),
    .apb_o(rsp), .first_timer_i(t1), .second_timer_i(t2),
    .adc_enabled_i(adc_en), .timer_reset_o(trst), .adc_start_o(adc_go),
    .compare_pin_o(cpin), .compare_pin_oe_o(cpin_oe), .pwm_out_o(pwm),
    .pwm_oe_o(pwm_en));
  cbp_timer_model #(.WRAP(WRAP)) tmod (.clock_i(clock_i),
    .reset_i(reset_i), .timer_reset_i(trst), .first_timer_o(t1),
    .second_timer_o(t2));

  task automatic check(input string what, input logic [32:0] seen,
                       input logic [32:0] exp);
    checks_done++;
    if (seen !== exp) begin
      errors++;
      $display("mismatch %s expected %0h seen %0h", what, exp, seen);
    end
  endtask

  task automatic finish_test();
    $display("checks %0d mismatches %0d", checks_done, errors);
    if (errors == 0 && checks_done > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  // read expectations wait in the queue until pready shows the data
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] wd, input logic [32:0] e);
    @(posedge clock_i);
    req <= '{1'b1, 1'b0, w, a, wd};
    if (!w)
      expq.push_back(e);
    @(posedge clock_i);
    req.penable <= 1'b1;
    do @(posedge clock_i); while (rsp.pready !== 1'b1);
    req.psel <= 1'b0;
    req.penable <= 1'b0;
  endtask

  // returns just after the edge that saw the match
  task automatic wait_match(input logic sec);
    #1;
    repeat (3 * WRAP) begin
      if ((sec ? t2 : t1) === v)
        break;
      @(posedge clock_i);
      #1;
    end
    @(posedge clock_i);
    #1;
  endtask

  task automatic pwm_case(input logic [1:0] cfg, input logic [1:0] pol,
      input logic [6:0] dead, input logic [1:0] pre, input int p,
      input int ex[4], input logic [3:0] use_m);
    int cnt[4];
    logic [32:0] oe_exp;
    cnt = '{0, 0, 0, 0};
    oe_exp = (cfg == cbp_pkg::CFG_HALF) ? 33'h3 : 33'hF;
    if (cfg == cbp_pkg::CFG_SINGLE)
      oe_exp = 33'h1;
    apb(1'b1, cbp_pkg::OFS_DUTY_HIGH, 32'(d >> 2), 33'h0);
    apb(1'b1, cbp_pkg::OFS_DEADBAND, {25'h0, dead}, 33'h0);
    apb(1'b1, cbp_pkg::OFS_PRESCALE, {30'h0, pre}, 33'h0);
    apb(1'b1, cbp_pkg::OFS_CONTROL, {24'h0, cfg, 2'(d), 2'h3, pol}, 33'h0);
    repeat (2 * p) @(posedge clock_i);
    repeat (p) begin
      @(posedge clock_i);
      #1;
      for (int i = 0; i < 4; i++)
        cnt[i] += int'(pwm[i] === 1'b1);
    end
    for (int i = 0; i < 4; i++)
      if (use_m[i])
        check("pwm_count", 33'(cnt[i]), 33'(ex[i]));
    check("pwm_enable", {29'h0, pwm_en}, oe_exp);
  endtask

  always @(posedge clock_i) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      errors++;
      finish_test();
    end
    if (rsp.pready === 1'b1 && req.psel && !req.pwrite) begin
      if (expq.size() == 0)
        check("read_unexpected", 33'h1, 33'h0);
      else
        check("read_data", {rsp.pslverr, rsp.prdata}, expq.pop_front());
    end
  end

  initial begin
    void'($urandom(88));
    repeat (5) @(posedge clock_i);
    reset_i <= 1'b0;
    apb(1'b0, cbp_pkg::OFS_CONTROL, 32'h0, 33'h0);
    apb(1'b0, cbp_pkg::OFS_STATUS, 32'h0, 33'h0);
    apb(1'b0, 8'h20, 32'h0, 33'h1_0000_0000);
    check("pwm_idle", {25'h0, pwm_en, pwm}, 33'h0);
    $display("test reset done");
    v = 16'(2 + $urandom % (WRAP - 4));
    apb(1'b1, cbp_pkg::OFS_COMPARE, {16'h0, v}, 33'h0);
    for (int i = 0; i < 4; i++) begin
      apb(1'b1, cbp_pkg::OFS_CONTROL, {28'h0, modes[i]}, 33'h0);
      wait_match(1'b0);
      check("compare_pin", {32'h0, cpin}, {32'h0, pins[i]});
      check("pin_enable", {32'h0, cpin_oe}, {32'h0, i != 0});
      apb(1'b0, cbp_pkg::OFS_STATUS, 32'h0, {31'h0, pins[i], 1'b1});
    end
    $display("test compare done");
    apb(1'b1, cbp_pkg::OFS_TIMER_ASSIGN, 32'h1, 33'h0);
    adc_en <= 1'b1;
    apb(1'b1, cbp_pkg::OFS_CONTROL, {28'h0, cbp_pkg::MODE_TRIGGER}, 33'h0);
    for (int k = 0; k < 2; k++) begin
      wait_match(1'b1);
      check("timer_reset", {31'h0, trst}, 33'h2);
      check("adc_start", {32'h0, adc_go}, {32'h0, ~k[0]});
      @(posedge clock_i);
      adc_en <= 1'b0;
      #1;
      check("second_timer", {17'h0, t2}, 33'h0);
    end
    // reserved assignment code: no match may disturb the preset pin
    apb(1'b1, cbp_pkg::OFS_TIMER_ASSIGN, 32'h4, 33'h0);
    apb(1'b1, cbp_pkg::OFS_CONTROL, {28'h0, cbp_pkg::MODE_CLEAR}, 33'h0);
    #1;
    check("pin_preset", {32'h0, cpin}, 33'h1);
    repeat (WRAP) @(posedge clock_i);
    #1;
    check("reserved_idle", {32'h0, cpin}, 33'h1);
    apb(1'b1, cbp_pkg::OFS_CONTROL, 32'h0, 33'h0);
    @(posedge clock_i);
    #1;
    check("pin_cleared", {32'h0, cpin}, 33'h0);
    apb(1'b1, cbp_pkg::OFS_STATUS, 32'h1, 33'h0);
    apb(1'b0, cbp_pkg::OFS_STATUS, 32'h0, 33'h0);
    $display("test trigger done");
    apb(1'b1, cbp_pkg::OFS_PERIOD_LIMIT, 32'hF, 33'h0);
    d = 8 + int'($urandom % 40);
    pwm_case(cbp_pkg::CFG_HALF, 2'h0, 7'h1, 2'h0, 64,
      '{d - 4, 60 - d, 0, 0}, 4'h3);
    pwm_case(cbp_pkg::CFG_FWD, 2'h0, 7'h0, 2'h0, 64,
      '{64, 0, 0, d}, 4'hF);
    pwm_case(cbp_pkg::CFG_REV, 2'h3, 7'h0, 2'h0, 64,
      '{64, 64 - d, 0, 64}, 4'hF);
    pwm_case(cbp_pkg::CFG_FWD, 2'h1, 7'h0, 2'h0, 64,
      '{64, 64, 0, 64 - d}, 4'hF);
    pwm_case(cbp_pkg::CFG_SINGLE, 2'h2, 7'h0, 2'h1, 256,
      '{256 - 4 * d, 0, 0, 0}, 4'h1);
    d = 20;
    pwm_case(cbp_pkg::CFG_HALF, 2'h0, 7'hA, 2'h0, 64,
      '{0, 4, 0, 0}, 4'h3);
    pwm_case(cbp_pkg::CFG_SINGLE, 2'h0, 7'h0, 2'h2, 1024,
      '{16 * d, 0, 0, 0}, 4'h1);
    $display("test pwm done");
    finish_test();
  end
endmodule

`default_nettype wire
